// ==== pin_function_and_drive_select.sv ====
// Pin function, drive level and port supply selection registers
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pin_function_and_drive_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pad inputs, asynchronous
  input wire logic [7:0] pa_pad_in,
  input wire logic [7:0] pb_pad_in,
  input wire logic [7:0] pc_pad_in,
  input wire logic [5:0] pd_pad_in,
  // Peripheral outputs that may take a pin
  input wire logic timer0_out,
  input wire logic std_timer_out,
  // Output function selects, two bits per pin
  output logic [15:0] pa_func_sel,
  output logic [15:0] pb_func_sel,
  output logic [11:0] pc_func_sel,
  output logic [7:0] pd_func_sel,
  // Timer outputs onto their pins
  output logic pa3_alt_sel,
  output logic pa3_alt_dout,
  output logic pa1_alt_sel,
  output logic pa1_alt_dout,
  // Drive levels, two bits per pin
  output logic [15:0] pc_drive_level,
  output logic [11:0] pd_drive_level,
  // Port supply
  output logic pa4_io_supply_sel,
  output logic [3:0] pc_io_supply_en,
  // Routed peripheral inputs
  output logic tclk0_in,
  output logic tclk1_in,
  output logic std_tclk_in,
  output logic capture_in,
  output logic irq0_in,
  output logic irq1_in
);

  typedef struct packed {
    logic [pin_cfg_pkg::NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic pa3_alt;
    logic pa1_alt;
    logic pa3_dout;
    logic pa1_dout;
    logic pa4_supply;
    logic [3:0] pc_supply;
  } cfg_state_t;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;

  logic [29:0] pads_sync;

  route_if rt ();

  // Maps a register offset to its slot, SLOT_NONE when unmapped
  function automatic logic [3:0] reg_slot(input logic [3:0] a);
    if (a == pin_cfg_pkg::OFF_DRIVE_B) begin
      reg_slot = pin_cfg_pkg::OFF_DRIVE_B;
    end else if (a == pin_cfg_pkg::OFF_SUPPLY) begin
      reg_slot = pin_cfg_pkg::OFF_SUPPLY;
    end else if (a == pin_cfg_pkg::OFF_PA_LO) begin
      reg_slot = pin_cfg_pkg::OFF_PA_LO;
    end else if (a == pin_cfg_pkg::OFF_PA_HI) begin
      reg_slot = pin_cfg_pkg::OFF_PA_HI;
    end else if (a == pin_cfg_pkg::OFF_PB_LO) begin
      reg_slot = pin_cfg_pkg::OFF_PB_LO;
    end else if (a == pin_cfg_pkg::OFF_PB_HI) begin
      reg_slot = pin_cfg_pkg::OFF_PB_HI;
    end else if (a == pin_cfg_pkg::OFF_PC_LO) begin
      reg_slot = pin_cfg_pkg::OFF_PC_LO;
    end else if (a == pin_cfg_pkg::OFF_PC_HI) begin
      reg_slot = pin_cfg_pkg::OFF_PC_HI;
    end else if (a == pin_cfg_pkg::OFF_PD_LO) begin
      reg_slot = pin_cfg_pkg::OFF_PD_LO;
    end else if (a == pin_cfg_pkg::OFF_TCLK_ROUTE) begin
      reg_slot = pin_cfg_pkg::OFF_TCLK_ROUTE;
    end else if (a == pin_cfg_pkg::OFF_CAP_ROUTE) begin
      reg_slot = pin_cfg_pkg::OFF_CAP_ROUTE;
    end else if (a == pin_cfg_pkg::OFF_IRQ_ROUTE) begin
      reg_slot = pin_cfg_pkg::OFF_IRQ_ROUTE;
    end else begin
      reg_slot = pin_cfg_pkg::SLOT_NONE;
    end
  endfunction

  // Pulls one two-bit field out of a register
  function automatic logic [1:0] field2(input logic [7:0] r, input int lsb);
    field2 = r[lsb +: 2];
  endfunction

  // Pads pass two flops before any logic sees them
  pin_sync2 #(
    .W(30)
  ) u_pad_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pad_in({pd_pad_in, pc_pad_in, pb_pad_in, pa_pad_in}),
    .pad_sync(pads_sync)
  );

  always_comb begin
    logic [3:0] slot;
    logic [pin_cfg_pkg::NUM_REGS-1:0][7:0] r;
    logic io_sel;
    logic pa4_sup;
    slot = 4'h0;
    r = '0;
    io_sel = 1'b0;
    pa4_sup = 1'b0;
    nxt_st = st_ff;
    slot = reg_slot(reg_addr);

    // Write lands in the register, so its effect shows next cycle
    if (reg_wr && (slot != pin_cfg_pkg::SLOT_NONE)) begin
      // Unimplemented bits are never stored and so read as zero
      nxt_st.regs[slot] = reg_wdata & pin_cfg_pkg::REG_WMASK[slot];
    end

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = pin_cfg_pkg::RDATA_IDLE;
    if (reg_rd && (slot != pin_cfg_pkg::SLOT_NONE)) begin
      nxt_st.rdata = st_ff.regs[slot];
    end

    // Derived controls follow the register values being loaded
    r = nxt_st.regs;
    nxt_st.pa3_alt = (field2(r[pin_cfg_pkg::OFF_PA_LO], pin_cfg_pkg::PA3_FUNC_LSB)
      == pin_cfg_pkg::FUNC_ALT);
    nxt_st.pa1_alt = (field2(r[pin_cfg_pkg::OFF_PA_LO], pin_cfg_pkg::PA1_FUNC_LSB)
      == pin_cfg_pkg::FUNC_ALT);
    pa4_sup = (field2(r[pin_cfg_pkg::OFF_PA_HI], pin_cfg_pkg::PA4_FUNC_LSB)
      == pin_cfg_pkg::FUNC_ALT);
    nxt_st.pa4_supply = pa4_sup;

    // Only the upper bit of the supply field matters
    io_sel = r[pin_cfg_pkg::OFF_SUPPLY][pin_cfg_pkg::SUPPLY_IO_BIT];
    // Without PA4 as the supply pin the port stays on the core supply
    nxt_st.pc_supply = {4{io_sel & pa4_sup}} & ~pin_cfg_pkg::PC_LO_ANALOG_MASK;

    // Peripheral drive retimed so the pin output comes from a flop
    nxt_st.pa3_dout = timer0_out & nxt_st.pa3_alt;
    nxt_st.pa1_dout = std_timer_out & nxt_st.pa1_alt;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Router side of the carrier
  assign rt.pa_s = pads_sync[7:0];
  assign rt.pb_s = pads_sync[15:8];
  assign rt.pc_s = pads_sync[23:16];
  assign rt.pd_s = pads_sync[29:24];
  assign rt.tclk0_sel = st_ff.regs[pin_cfg_pkg::OFF_TCLK_ROUTE][pin_cfg_pkg::TCLK0_SEL_BIT];
  assign rt.tclk1_sel = st_ff.regs[pin_cfg_pkg::OFF_TCLK_ROUTE][pin_cfg_pkg::TCLK1_SEL_BIT];
  assign rt.std_tclk_sel =
    st_ff.regs[pin_cfg_pkg::OFF_TCLK_ROUTE][pin_cfg_pkg::STD_TCLK_SEL_BIT];
  assign rt.capture_sel =
    st_ff.regs[pin_cfg_pkg::OFF_CAP_ROUTE][pin_cfg_pkg::CAPTURE_SEL_BIT];
  assign rt.irq0_sel = st_ff.regs[pin_cfg_pkg::OFF_IRQ_ROUTE][pin_cfg_pkg::IRQ0_SEL_BIT];
  assign rt.irq1_sel = st_ff.regs[pin_cfg_pkg::OFF_IRQ_ROUTE][pin_cfg_pkg::IRQ1_SEL_BIT];
  assign rt.pa4_is_supply = st_ff.pa4_supply;
  assign rt.pa3_is_alt = st_ff.pa3_alt;
  assign rt.pa1_is_alt = st_ff.pa1_alt;

  input_router u_router (
    .mclk(mclk),
    .rst_n(rst_n),
    .rt(rt)
  );

  // Register port
  assign reg_rdata = st_ff.rdata;

  // Output function selects, unimplemented pin fields read as zero
  assign pa_func_sel = {
    st_ff.regs[pin_cfg_pkg::OFF_PA_HI][pin_cfg_pkg::PA7_FUNC_LSB +: 2],
    st_ff.regs[pin_cfg_pkg::OFF_PA_HI][pin_cfg_pkg::PA6_FUNC_LSB +: 2],
    2'h0,
    st_ff.regs[pin_cfg_pkg::OFF_PA_HI][pin_cfg_pkg::PA4_FUNC_LSB +: 2],
    st_ff.regs[pin_cfg_pkg::OFF_PA_LO][pin_cfg_pkg::PA3_FUNC_LSB +: 2],
    2'h0,
    st_ff.regs[pin_cfg_pkg::OFF_PA_LO][pin_cfg_pkg::PA1_FUNC_LSB +: 2],
    2'h0
  };
  assign pb_func_sel = {st_ff.regs[pin_cfg_pkg::OFF_PB_HI], st_ff.regs[pin_cfg_pkg::OFF_PB_LO]};
  assign pc_func_sel = {st_ff.regs[pin_cfg_pkg::OFF_PC_HI][3:0],
    st_ff.regs[pin_cfg_pkg::OFF_PC_LO]};
  assign pd_func_sel = st_ff.regs[pin_cfg_pkg::OFF_PD_LO];

  // Timer outputs
  assign pa3_alt_sel = st_ff.pa3_alt;
  assign pa3_alt_dout = st_ff.pa3_dout;
  assign pa1_alt_sel = st_ff.pa1_alt;
  assign pa1_alt_dout = st_ff.pa1_dout;

  // Drive codes pass unchanged; the pad maps code to current
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pc_drive
      if (gi < 4) begin : g_lo
        assign pc_drive_level[2*gi +: 2] =
          st_ff.regs[pin_cfg_pkg::OFF_DRIVE_B][pin_cfg_pkg::DRV_PC3_0_LSB +: 2];
      end else begin : g_hi
        assign pc_drive_level[2*gi +: 2] =
          st_ff.regs[pin_cfg_pkg::OFF_DRIVE_B][pin_cfg_pkg::DRV_PC7_4_LSB +: 2];
      end
    end
    for (gi = 0; gi < 6; gi++) begin : g_pd_drive
      if (gi < 4) begin : g_lo
        assign pd_drive_level[2*gi +: 2] =
          st_ff.regs[pin_cfg_pkg::OFF_DRIVE_B][pin_cfg_pkg::DRV_PD3_0_LSB +: 2];
      end else begin : g_hi
        assign pd_drive_level[2*gi +: 2] =
          st_ff.regs[pin_cfg_pkg::OFF_DRIVE_B][pin_cfg_pkg::DRV_PD5_4_LSB +: 2];
      end
    end
  endgenerate

  // Port supply
  assign pa4_io_supply_sel = st_ff.pa4_supply;
  assign pc_io_supply_en = st_ff.pc_supply;

  // Routed inputs, retimed inside the router
  assign tclk0_in = rt.tclk0;
  assign tclk1_in = rt.tclk1;
  assign std_tclk_in = rt.std_tclk;
  assign capture_in = rt.capture;
  assign irq0_in = rt.irq0;
  assign irq1_in = rt.irq1;

endmodule // pin_function_and_drive_select
`default_nettype wire

// ==== pin_cfg_pkg.sv ====
// Shared constants for the pin function and drive select block
package pin_cfg_pkg;

  localparam int NUM_REGS = 12;

  // Register offsets on the plain register port
  localparam logic [3:0] OFF_DRIVE_B = 4'h0;
  localparam logic [3:0] OFF_SUPPLY = 4'h1;
  localparam logic [3:0] OFF_PA_LO = 4'h2;
  localparam logic [3:0] OFF_PA_HI = 4'h3;
  localparam logic [3:0] OFF_PB_LO = 4'h4;
  localparam logic [3:0] OFF_PB_HI = 4'h5;
  localparam logic [3:0] OFF_PC_LO = 4'h6;
  localparam logic [3:0] OFF_PC_HI = 4'h7;
  localparam logic [3:0] OFF_PD_LO = 4'h8;
  localparam logic [3:0] OFF_TCLK_ROUTE = 4'h9;
  localparam logic [3:0] OFF_CAP_ROUTE = 4'hA;
  localparam logic [3:0] OFF_IRQ_ROUTE = 4'hB;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // Implemented bits of each register, slot 0 in the low byte
  localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {
    8'h03, 8'h01, 8'h61, 8'hFF, 8'h0F, 8'hFF,
    8'hFF, 8'hFF, 8'hF3, 8'hCC, 8'h03, 8'hFF
  };
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Field positions
  localparam int DRV_PD5_4_LSB = 6;
  localparam int DRV_PD3_0_LSB = 4;
  localparam int DRV_PC7_4_LSB = 2;
  localparam int DRV_PC3_0_LSB = 0;
  localparam int SUPPLY_SEL_LSB = 0;
  localparam int SUPPLY_IO_BIT = 1;
  localparam int PA3_FUNC_LSB = 6;
  localparam int PA1_FUNC_LSB = 2;
  localparam int PA4_FUNC_LSB = 0;
  localparam int PA6_FUNC_LSB = 4;
  localparam int PA7_FUNC_LSB = 6;
  localparam int TCLK1_SEL_BIT = 6;
  localparam int TCLK0_SEL_BIT = 5;
  localparam int STD_TCLK_SEL_BIT = 0;
  localparam int CAPTURE_SEL_BIT = 0;
  localparam int IRQ1_SEL_BIT = 1;
  localparam int IRQ0_SEL_BIT = 0;

  // Low port C pins with an analog function; none have one
  localparam logic [3:0] PC_LO_ANALOG_MASK = 4'h0;

  typedef enum logic [1:0] {
    DRIVE_LEVEL0 = 2'h0,
    DRIVE_LEVEL1 = 2'h1,
    DRIVE_LEVEL2 = 2'h2,
    DRIVE_LEVEL3 = 2'h3
  } drive_level_t;

  typedef enum logic [1:0] {
    FUNC_SHARED0 = 2'h0,
    FUNC_SHARED1 = 2'h1,
    FUNC_SHARED2 = 2'h2,
    FUNC_ALT = 2'h3
  } func_code_t;

endpackage

// ==== route_if.sv ====
// Carrier between the register side and the input source router
`timescale 1ns/100ps
`default_nettype none
interface route_if;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic [5:0] pd_s;
  logic tclk0_sel;
  logic tclk1_sel;
  logic std_tclk_sel;
  logic capture_sel;
  logic irq0_sel;
  logic irq1_sel;
  logic pa4_is_supply;
  logic pa3_is_alt;
  logic pa1_is_alt;
  logic tclk0;
  logic tclk1;
  logic std_tclk;
  logic capture;
  logic irq0;
  logic irq1;

  modport cfg (
    output pa_s, pb_s, pc_s, pd_s, tclk0_sel, tclk1_sel, std_tclk_sel,
    output capture_sel, irq0_sel, irq1_sel, pa4_is_supply, pa3_is_alt, pa1_is_alt,
    input tclk0, tclk1, std_tclk, capture, irq0, irq1
  );
  modport mux (
    input pa_s, pb_s, pc_s, pd_s, tclk0_sel, tclk1_sel, std_tclk_sel,
    input capture_sel, irq0_sel, irq1_sel, pa4_is_supply, pa3_is_alt, pa1_is_alt,
    output tclk0, tclk1, std_tclk, capture, irq0, irq1
  );
endinterface
`default_nettype wire

// ==== pin_sync2.sv ====
// Two-stage synchroniser for pad inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pads and synchronised copy
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pad_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pad_sync = st_ff.stable;
endmodule // pin_sync2
`default_nettype wire

// ==== input_router.sv ====
// Chooses which pad feeds each peripheral input
`timescale 1ns/100ps
`default_nettype none
module input_router (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Route selects in, routed inputs out
  route_if.mux rt
);
  typedef struct packed {
    logic tclk0;
    logic tclk1;
    logic std_tclk;
    logic capture;
    logic irq0;
    logic irq1;
  } route_state_t;

  route_state_t st_ff;
  route_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // Pad lost to the supply or a timer output reads as low
    nxt_st.tclk0 = rt.tclk0_sel ? rt.pb_s[2] : (rt.pa_s[4] & ~rt.pa4_is_supply);
    nxt_st.tclk1 = rt.tclk1_sel ? rt.pb_s[3] : rt.pd_s[0];
    nxt_st.std_tclk = rt.std_tclk_sel ? rt.pb_s[1] : rt.pa_s[5];
    nxt_st.capture = rt.capture_sel ? rt.pc_s[0] : rt.pb_s[6];
    nxt_st.irq0 = rt.irq0_sel ? rt.pb_s[4] : (rt.pa_s[3] & ~rt.pa3_is_alt);
    nxt_st.irq1 = rt.irq1_sel ? rt.pb_s[5] : (rt.pa_s[1] & ~rt.pa1_is_alt);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rt.tclk0 = st_ff.tclk0;
  assign rt.tclk1 = st_ff.tclk1;
  assign rt.std_tclk = st_ff.std_tclk;
  assign rt.capture = st_ff.capture;
  assign rt.irq0 = st_ff.irq0;
  assign rt.irq1 = st_ff.irq1;
endmodule // input_router
`default_nettype wire

// ==== pin_cfg_chk.sv ====
// Assertion checker for the pin function and drive select block
`timescale 1ns/100ps
`default_nettype none
module pin_cfg_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Timer outputs
  input wire logic timer0_out,
  input wire logic std_timer_out,
  // Pin controls
  input wire logic [15:0] pa_func_sel,
  input wire logic pa3_alt_sel,
  input wire logic pa3_alt_dout,
  input wire logic pa1_alt_sel,
  input wire logic pa1_alt_dout,
  input wire logic [15:0] pc_drive_level,
  input wire logic [11:0] pd_drive_level,
  input wire logic pa4_io_supply_sel,
  input wire logic [3:0] pc_io_supply_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_drive_pc_groups: assert property (pc_drive_level == {{4{pc_drive_level[15:14]}}, {4{pc_drive_level[1:0]}}})
    else $error("port C drive groups differ");
  chk_drive_pd_groups: assert property (pd_drive_level == {{2{pd_drive_level[11:10]}}, {4{pd_drive_level[1:0]}}})
    else $error("port D drive groups differ");
  chk_drive_write: assert property (reg_wr && reg_addr == pin_cfg_pkg::OFF_DRIVE_B |=>
    {pd_drive_level[11:10], pd_drive_level[1:0], pc_drive_level[15:14], pc_drive_level[1:0]}
    == $past(reg_wdata)) else $error("drive levels do not follow write");
  chk_supply_write: assert property (reg_wr && reg_addr == pin_cfg_pkg::OFF_SUPPLY && pa4_io_supply_sel
    |=> pc_io_supply_en == {4{$past(reg_wdata[1])}}) else $error("supply select wrong");
  chk_supply_gate: assert property (!pa4_io_supply_sel |-> pc_io_supply_en == 4'h0)
    else $error("io supply used without supply pin");
  chk_pa_alt_codes: assert property (pa3_alt_sel == (pa_func_sel[7:6] == 2'h3) && pa1_alt_sel == (pa_func_sel[3:2] == 2'h3))
    else $error("timer output select wrong");
  chk_pa4_supply: assert property (pa4_io_supply_sel == (pa_func_sel[9:8] == 2'h3))
    else $error("supply pin select wrong");
  chk_alt_dout: assert property (pa3_alt_dout == ($past(timer0_out) && pa3_alt_sel) && pa1_alt_dout == ($past(std_timer_out) && pa1_alt_sel))
    else $error("timer output data wrong");
  chk_supply_read: assert property (reg_rd && reg_addr == pin_cfg_pkg::OFF_SUPPLY |=> reg_rdata[7:2] == 6'h00)
    else $error("supply unused bits nonzero");
  chk_pa_lo_read: assert property (reg_rd && reg_addr == pin_cfg_pkg::OFF_PA_LO |=> (reg_rdata & 8'h33) == 8'h00)
    else $error("port A unused bits nonzero");
endmodule // pin_cfg_chk

bind pin_function_and_drive_select pin_cfg_chk chk_u (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .timer0_out(timer0_out), .std_timer_out(std_timer_out),
  .pa_func_sel(pa_func_sel), .pa3_alt_sel(pa3_alt_sel), .pa3_alt_dout(pa3_alt_dout),
  .pa1_alt_sel(pa1_alt_sel), .pa1_alt_dout(pa1_alt_dout), .pc_drive_level(pc_drive_level),
  .pd_drive_level(pd_drive_level), .pa4_io_supply_sel(pa4_io_supply_sel),
  .pc_io_supply_en(pc_io_supply_en));
`default_nettype wire

// ==== pin_world_model.sv ====
// Behavioural pads and timer outputs beyond the pin block
`timescale 1ns/100ps
`default_nettype none
module pin_world_model (
  // Clock
  input wire logic mclk,
  // Requested pad levels {pd, pc, pb, pa}
  input wire logic [29:0] pad_req,
  // Pads and timer outputs
  output logic [7:0] pa_pad,
  output logic [7:0] pb_pad,
  output logic [7:0] pc_pad,
  output logic [5:0] pd_pad,
  output logic timer0_out,
  output logic std_timer_out
);
  initial begin
    {pd_pad, pc_pad, pb_pad, pa_pad} = 30'h0;
    timer0_out = 1'b0;
    std_timer_out = 1'b1;
  end
  // Pins are inputs here, so pads are driven only from outside
  always @(posedge mclk) begin
    {pd_pad, pc_pad, pb_pad, pa_pad} <= pad_req;
  end
  // Toggling every cycle exposes any off-by-one delay
  always @(posedge mclk) begin
    timer0_out <= ~timer0_out;
    std_timer_out <= ~std_timer_out;
  end
endmodule // pin_world_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench for the pin function and drive select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  logic mclk, rst_n, reg_wr, reg_rd, t0, st, a3s, a3d, a1s, a1d, pa4s;
  logic [3:0] reg_addr, sup_en;
  logic [7:0] reg_wdata, reg_rdata, pa_pad, pb_pad, pc_pad, pd_fs, rd_val;
  logic [5:0] pd_pad, routed;
  logic [29:0] pad_req;
  logic [15:0] pa_fs, pb_fs, pc_drv;
  logic [11:0] pc_fs, pd_drv;
  int fails;
  int samples_checked;

  pin_world_model world_u (.mclk(mclk), .pad_req(pad_req), .pa_pad(pa_pad), .pb_pad(pb_pad),
    .pc_pad(pc_pad), .pd_pad(pd_pad), .timer0_out(t0), .std_timer_out(st));
  pin_function_and_drive_select dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pa_pad_in(pa_pad), .pb_pad_in(pb_pad), .pc_pad_in(pc_pad), .pd_pad_in(pd_pad),
    .timer0_out(t0), .std_timer_out(st), .pa_func_sel(pa_fs), .pb_func_sel(pb_fs),
    .pc_func_sel(pc_fs), .pd_func_sel(pd_fs), .pa3_alt_sel(a3s), .pa3_alt_dout(a3d),
    .pa1_alt_sel(a1s), .pa1_alt_dout(a1d), .pc_drive_level(pc_drv), .pd_drive_level(pd_drv),
    .pa4_io_supply_sel(pa4s), .pc_io_supply_en(sup_en), .tclk0_in(routed[0]),
    .tclk1_in(routed[1]), .std_tclk_in(routed[2]), .capture_in(routed[3]),
    .irq0_in(routed[4]), .irq1_in(routed[5]));

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic s_reset;
    for (int i = 0; i < 12; i++) begin
      rd(i[3:0], rd_val);
      `CHK(rd_val, 8'h00)
    end
    `CHK({pa_fs, pb_fs, pc_fs, pd_fs, pc_drv, pd_drv, sup_en}, 84'h0)
  endtask
  task automatic s_masks;
    logic [7:0] mask [16] = '{8'hFF, 8'h03, 8'hCC, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
      8'hFF, 8'h61, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++) begin
      wr(i[3:0], 8'hFF);
      rd(i[3:0], rd_val);
      `CHK(rd_val, mask[i])
      wr(i[3:0], 8'h00);
    end
  endtask
  task automatic s_drive;
    logic [1:0] c [4];
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) c[j] = 2'(k + j);
      wr(pin_cfg_pkg::OFF_DRIVE_B, {c[3], c[2], c[1], c[0]});
      `CHK(pc_drv, {{4{c[1]}}, {4{c[0]}}})
      `CHK(pd_drv, {{2{c[3]}}, {4{c[2]}}})
    end
  endtask
  task automatic s_supply;
    wr(pin_cfg_pkg::OFF_SUPPLY, 8'h02);
    `CHK(sup_en, 4'h0)
    wr(pin_cfg_pkg::OFF_PA_HI, 8'h03);
    `CHK({pa4s, sup_en}, 5'h1F)
    wr(pin_cfg_pkg::OFF_SUPPLY, 8'h01);
    `CHK(sup_en, 4'h0)
    wr(pin_cfg_pkg::OFF_SUPPLY, 8'h03);
    `CHK(sup_en, 4'hF)
    wr(pin_cfg_pkg::OFF_PA_HI, 8'h00);
    `CHK({pa4s, sup_en}, 5'h00)
    wr(pin_cfg_pkg::OFF_SUPPLY, 8'h00);
  endtask
  task automatic s_pa_alt;
    for (int k = 0; k < 4; k++) begin
      wr(pin_cfg_pkg::OFF_PA_LO, {2'(k), 2'h0, 2'(k), 2'h0});
      `CHK({pa_fs[7:6], pa_fs[3:2], a3s, a1s}, {2'(k), 2'(k), k == 3, k == 3})
      @(posedge mclk);
      #1;
      `CHK({a3d, a1d}, (k == 3) ? {~t0, ~st} : 2'b00)
    end
    wr(pin_cfg_pkg::OFF_PA_LO, 8'h00);
  endtask
  task automatic s_func;
    wr(pin_cfg_pkg::OFF_PB_LO, 8'h5A);
    wr(pin_cfg_pkg::OFF_PB_HI, 8'hC3);
    wr(pin_cfg_pkg::OFF_PC_LO, 8'h96);
    wr(pin_cfg_pkg::OFF_PC_HI, 8'h0E);
    wr(pin_cfg_pkg::OFF_PD_LO, 8'h3C);
    wr(pin_cfg_pkg::OFF_PA_HI, 8'hF0);
    `CHK({pb_fs, pc_fs, pd_fs, pa_fs[15:8]}, 44'hC35AE963CF0)
    for (int i = 3; i < 9; i++) wr(i[3:0], 8'h00);
  endtask
  task automatic s_route;
    logic [29:0] pads [2] = '{{6'h01, 8'h00, 8'h40, 8'h3A}, {6'h00, 8'h01, 8'h3E, 8'h00}};
    for (int s = 0; s < 2; s++) begin
      wr(pin_cfg_pkg::OFF_TCLK_ROUTE, s ? 8'h61 : 8'h00);
      wr(pin_cfg_pkg::OFF_CAP_ROUTE, 8'(s));
      wr(pin_cfg_pkg::OFF_IRQ_ROUTE, s ? 8'h03 : 8'h00);
      for (int p = 0; p < 2; p++) begin
        @(posedge mclk);
        pad_req <= pads[p];
        repeat (5) @(posedge mclk);
        #1;
        `CHK(routed, (s == p) ? 6'h3F : 6'h00)
      end
    end
  endtask
  task automatic s_midreset;
    wr(pin_cfg_pkg::OFF_DRIVE_B, 8'hFF);
    wr(pin_cfg_pkg::OFF_PA_LO, 8'hCC);
    `CHK({pc_drv, a3s, a1s}, 18'h3FFFF)
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    s_reset();
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pad_req = 30'h0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    s_reset();
    s_masks();
    s_drive();
    s_supply();
    s_pa_alt();
    s_func();
    s_route();
    s_midreset();
    stop_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
